// file: include/bpfe_pkg.sv
// Package for the branch prediction front end: sizes, control fields, carriers
// ----------------------------------------------------------------------------
// What this block does
// [R01] Indirect register jump stalls fetch five cycles
// [R02] Target cache: 32 entries, two-way set
// [R03] Target cache hit taken: no bubble
// [R04] Hit but predicted not-taken: one bubble
// [R05] Software may switch target cache off
// [R06] Eight-bit global history, gshare predictor
// [R07] History updated speculatively, usable next cycle
// [R08] Bit 26 set: all eight history bits
// [R09] Bit 26 clear: bits 25:23 give count
// [R10] Prediction table: 2048 two-bit entries
// [R11] Index is history XOR branch PC
// [R12] Bits 26:23 zero: PC-only index
// [R13] Control bit 27 set: target cache unused
// [R14] Entries are saturating counters, MSB predicts
// ----------------------------------------------------------------------------
package bpfe_pkg;
	localparam int PC_W = 32;
	localparam int HIST_W = 8;
	localparam int BPT_ENTRIES = 2048;
	localparam int BPT_IDX_W = 11;
	localparam int BTC_ENTRIES = 32;
	localparam int BTC_WAYS = 2;
	localparam int BTC_SETS = 16;
	localparam int BTC_SET_W = 4;
	localparam int BTC_TAG_W = PC_W - BTC_SET_W - 2;
	localparam int PC_LSB = 2;
	// Diagnostic control field positions
	localparam int CTL_W = 32;
	localparam int CTL_HIST_LO = 23;
	localparam int CTL_HIST_HI = 26;
	localparam int CTL_HIST_ALL = 26;
	localparam int CTL_BTC_OFF = 27;
	// Indirect jump stall, in cycles
	localparam int JR_STALL_CYC = 5;
	localparam logic [2:0] JR_STALL_W3 = 3'h5;
	localparam logic [1:0] CNT_RESET = 2'h1;
	localparam logic [1:0] CNT_MAX = 2'h3;
	localparam logic [1:0] CNT_MIN = 2'h0;
	localparam logic [HIST_W-1:0] HIST_RESET = 8'h00;

	typedef struct packed {
		logic valid;
		logic [PC_W-1:0] pc;
		logic is_branch;
		logic is_indirect;
	} bpfe_fetch_t;

	typedef struct packed {
		logic valid;
		logic [PC_W-1:0] pc;
		logic taken;
		logic [PC_W-1:0] target;
		logic [BPT_IDX_W-1:0] idx;
	} bpfe_resolve_t;

	typedef struct packed {
		logic valid;
		logic taken;
		logic btc_hit;
		logic [PC_W-1:0] target;
		logic [BPT_IDX_W-1:0] idx;
	} bpfe_pred_t;

	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_STALL = 2'b10
	} bpfe_state_t;
endpackage

// file: rtl/bpfe_counter_table.sv
// Table of two-bit saturating prediction counters
`timescale 1ns/1ps
module bpfe_counter_table import bpfe_pkg::*; #(
	parameter int ENTRIES = BPT_ENTRIES,
	parameter int IDX_W = BPT_IDX_W
) (
	input wire logic clk, // Processor clock
	input wire logic rst_n, // Synchronised reset
	input wire logic [IDX_W-1:0] rd_idx, // Lookup index
	output logic rd_taken, // Upper counter bit
	input wire logic upd_en, // Resolved branch strobe
	input wire logic [IDX_W-1:0] upd_idx, // Index used at prediction
	input wire logic upd_taken // Resolved outcome
);
	logic [1:0] cnt_q [ENTRIES];
	logic [1:0] cnt_d [ENTRIES];

	// ------------------------------------------------------------------
	// Counter update
	// ------------------------------------------------------------------
	// [R10] per-entry counters
	genvar gi;
	generate
		for (gi = 0; gi < ENTRIES; gi++) begin : g_ent
			always_comb begin
				cnt_d[gi] = cnt_q[gi];
				// [R14] saturating count
				if (upd_en && upd_idx == IDX_W'(gi)) begin
					if (upd_taken && cnt_q[gi] != CNT_MAX) begin
						cnt_d[gi] = cnt_q[gi] + 2'h1;
					end else if (!upd_taken && cnt_q[gi] != CNT_MIN) begin
						cnt_d[gi] = cnt_q[gi] - 2'h1;
					end
				end
			end
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					cnt_q[gi] <= CNT_RESET;
				end else begin
					cnt_q[gi] <= cnt_d[gi];
				end
			end
		end
	endgenerate

	// [R14] upper bit predicts
	assign rd_taken = cnt_q[rd_idx][1];

	// [R14] saturation never wraps
	a_cnt_sat: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
		(upd_en && upd_taken && cnt_q[upd_idx] == CNT_MAX)
		|=> cnt_q[$past(upd_idx)] == CNT_MAX) else $error("counter wrapped up");
	a_cnt_dec: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
		(upd_en && !upd_taken && cnt_q[upd_idx] == CNT_MAX)
		|=> cnt_q[$past(upd_idx)] == 2'h2) else $error("counter missed decrement");
endmodule

// file: rtl/bpfe_front_end.sv
// Branch prediction front end: target cache, gshare indexing, jump stall
`timescale 1ns/1ps
module bpfe_front_end import bpfe_pkg::*; #(
	parameter int HW = HIST_W,
	parameter int STALL_CYC = JR_STALL_CYC
) (
	input wire logic clk, // Processor clock
	input wire logic reset_n, // Async reset, active low
	input wire logic [CTL_W-1:0] diag_ctl, // Diagnostic control word
	input wire bpfe_fetch_t fetch, // Fetch-stage instruction
	input wire bpfe_resolve_t resolve, // Resolved branch from pipeline
	output bpfe_pred_t pred, // Registered prediction
	output logic fetch_stall, // Fetch hold (indirect jump)
	output logic fetch_bubble // One-cycle fetch bubble
);
	// ------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------
	logic rst_s1_q, rst_n_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// ------------------------------------------------------------------
	// Control decode
	// ------------------------------------------------------------------
	logic btc_off;
	logic [3:0] hist_field;
	logic [HW-1:0] hist_mask;
	// [R05] software switch for target cache
	// [R13] bit 27 disables lookups
	assign btc_off = diag_ctl[CTL_BTC_OFF];
	assign hist_field = diag_ctl[CTL_HIST_HI:CTL_HIST_LO];
	// Mask of history bits in use; zero field gives empty mask
	always_comb begin
		hist_mask = '0;
		// [R08] bit 26 selects all bits
		if (diag_ctl[CTL_HIST_ALL]) begin
			hist_mask = '1;
		end else begin
			// [R09] count of low history bits
			for (int i = 0; i < HW; i++) begin
				if (i < int'(hist_field[2:0])) begin
					hist_mask[i] = 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Global history and index
	// ------------------------------------------------------------------
	logic [HW-1:0] ghist_q, ghist_d;
	logic [BPT_IDX_W-1:0] pc_idx, bpt_idx;
	logic bpt_taken;
	logic is_cond;
	assign pc_idx = fetch.pc[PC_LSB +: BPT_IDX_W];
	// [R11] XOR selected history with PC
	// [R12] empty mask leaves PC alone
	assign bpt_idx = pc_idx ^ BPT_IDX_W'(ghist_q & hist_mask);
	assign is_cond = fetch.valid && fetch.is_branch && !fetch.is_indirect && !fetch_stall;

	// [R06] shift in predicted outcome
	// [R07] speculative, visible next cycle
	always_comb begin
		ghist_d = ghist_q;
		if (is_cond) begin
			ghist_d = {ghist_q[HW-2:0], bpt_taken};
		end
	end
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ghist_q <= HIST_RESET;
		end else begin
			ghist_q <= ghist_d;
		end
	end

	// [R10] prediction table
	bpfe_counter_table #(.ENTRIES(BPT_ENTRIES), .IDX_W(BPT_IDX_W)) u_tbl (
		.clk(clk),
		.rst_n(rst_n_q),
		.rd_idx(bpt_idx),
		.rd_taken(bpt_taken),
		.upd_en(resolve.valid),
		.upd_idx(resolve.idx),
		.upd_taken(resolve.taken)
	);

	// ------------------------------------------------------------------
	// Branch target cache
	// ------------------------------------------------------------------
	// [R02] 16 sets by 2 ways
	logic btc_vld_q [BTC_SETS][BTC_WAYS];
	logic [BTC_TAG_W-1:0] btc_tag_q [BTC_SETS][BTC_WAYS];
	logic [PC_W-1:0] btc_tgt_q [BTC_SETS][BTC_WAYS];
	logic btc_lru_q [BTC_SETS];
	logic [BTC_SET_W-1:0] lk_set, wr_set;
	logic [BTC_TAG_W-1:0] lk_tag, wr_tag;
	logic [BTC_WAYS-1:0] lk_hit, wr_hit;
	logic btc_hit;
	logic [PC_W-1:0] btc_tgt;
	assign lk_set = fetch.pc[PC_LSB +: BTC_SET_W];
	assign lk_tag = fetch.pc[PC_W-1 -: BTC_TAG_W];
	assign wr_set = resolve.pc[PC_LSB +: BTC_SET_W];
	assign wr_tag = resolve.pc[PC_W-1 -: BTC_TAG_W];

	// Way compare for lookup and for fill
	genvar gw;
	generate
		for (gw = 0; gw < BTC_WAYS; gw++) begin : g_way
			assign lk_hit[gw] = btc_vld_q[lk_set][gw] && btc_tag_q[lk_set][gw] == lk_tag;
			assign wr_hit[gw] = btc_vld_q[wr_set][gw] && btc_tag_q[wr_set][gw] == wr_tag;
		end
	endgenerate
	// [R13] lookup gated while switched off
	assign btc_hit = !btc_off && (|lk_hit);
	assign btc_tgt = lk_hit[1] ? btc_tgt_q[lk_set][1] : btc_tgt_q[lk_set][0];

	// Fill on taken resolved branches; refresh matching way, else replace LRU
	logic wr_en, wr_way;
	assign wr_en = resolve.valid && resolve.taken && !btc_off;
	assign wr_way = (|wr_hit) ? wr_hit[1] : btc_lru_q[wr_set];
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			for (int s = 0; s < BTC_SETS; s++) begin
				btc_lru_q[s] <= 1'b0;
				for (int w = 0; w < BTC_WAYS; w++) begin
					btc_vld_q[s][w] <= 1'b0;
					btc_tag_q[s][w] <= '0;
					btc_tgt_q[s][w] <= '0;
				end
			end
		end else if (wr_en) begin
			// [R02] store previously-taken targets
			btc_vld_q[wr_set][wr_way] <= 1'b1;
			btc_tag_q[wr_set][wr_way] <= wr_tag;
			btc_tgt_q[wr_set][wr_way] <= resolve.target;
			btc_lru_q[wr_set] <= !wr_way;
		end
	end

	// ------------------------------------------------------------------
	// Fetch stall state machine
	// ------------------------------------------------------------------
	bpfe_state_t st_q, st_d;
	logic [2:0] stall_cnt_q, stall_cnt_d;
	logic jr_seen;
	assign jr_seen = fetch.valid && fetch.is_indirect;
	// [R01] hold fetch five cycles after indirect jump
	always_comb begin
		st_d = st_q;
		stall_cnt_d = stall_cnt_q;
		case (st_q)
			ST_RUN: begin
				if (jr_seen) begin
					st_d = ST_STALL;
					stall_cnt_d = 3'(STALL_CYC);
				end
			end
			ST_STALL: begin
				stall_cnt_d = stall_cnt_q - 3'h1;
				if (stall_cnt_q == 3'h1) begin
					st_d = ST_RUN;
				end
			end
			default: begin
				st_d = ST_RUN;
				stall_cnt_d = 3'h0;
			end
		endcase
	end
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			st_q <= ST_RUN;
			stall_cnt_q <= 3'h0;
		end else begin
			st_q <= st_d;
			stall_cnt_q <= stall_cnt_d;
		end
	end
	assign fetch_stall = (st_q == ST_STALL);

	// ------------------------------------------------------------------
	// Prediction output
	// ------------------------------------------------------------------
	bpfe_pred_t pred_d, pred_q;
	always_comb begin
		pred_d = '0;
		if (is_cond) begin
			pred_d.valid = 1'b1;
			pred_d.taken = bpt_taken;
			pred_d.btc_hit = btc_hit;
			// [R03] hit supplies target directly
			pred_d.target = btc_hit ? btc_tgt : '0;
			pred_d.idx = bpt_idx;
		end
	end
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pred_q <= '0;
		end else begin
			pred_q <= pred_d;
		end
	end
	assign pred = pred_q;
	// [R03] taken hit has no bubble
	// [R04] hit predicted not-taken bubbles once
	assign fetch_bubble = pred_q.valid && pred_q.btc_hit != pred_q.taken;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	a_jr_stall_len: assert property (@(posedge clk) disable iff (!rst_n_q) // [R01]
		(st_q == ST_RUN && jr_seen) |=> fetch_stall [*5] ##1 !fetch_stall)
		else $error("indirect stall length wrong");
	a_hit_bubble: assert property (@(posedge clk) disable iff (!rst_n_q) // [R04]
		(is_cond && btc_hit && !bpt_taken) |=> fetch_bubble ##1 !fetch_bubble || pred_q.valid)
		else $error("missing not-taken bubble");
	a_hit_nobubble: assert property (@(posedge clk) disable iff (!rst_n_q) // [R03]
		(is_cond && btc_hit && bpt_taken) |=> !fetch_bubble && pred.target == $past(btc_tgt))
		else $error("taken hit bubbled");
	a_btc_off: assert property (@(posedge clk) disable iff (!rst_n_q) // [R13]
		diag_ctl[CTL_BTC_OFF] |=> !pred.btc_hit)
		else $error("target cache used while off");
	a_hist_shift: assert property (@(posedge clk) disable iff (!rst_n_q) // [R07]
		is_cond |=> ghist_q[0] == $past(bpt_taken) && ghist_q[HW-1:1] == $past(ghist_q[HW-2:0]))
		else $error("history not shifted");
	a_hist_off: assert property (@(posedge clk) disable iff (!rst_n_q) // [R12]
		(hist_field == 4'h0) |-> bpt_idx == pc_idx)
		else $error("history used while disabled");
	a_hist_all: assert property (@(posedge clk) disable iff (!rst_n_q) // [R08]
		diag_ctl[CTL_HIST_ALL] |-> bpt_idx == (pc_idx ^ BPT_IDX_W'(ghist_q)))
		else $error("full history not used");
	a_hist_cnt: assert property (@(posedge clk) disable iff (!rst_n_q) // [R09]
		(!diag_ctl[CTL_HIST_ALL] && hist_field[2:0] == 3'h3)
		|-> bpt_idx == (pc_idx ^ BPT_IDX_W'(ghist_q & 8'h07)))
		else $error("history count wrong");
	c_jr: cover property (@(posedge clk) disable iff (!rst_n_q) jr_seen && st_q == ST_RUN);
	c_hit_taken: cover property (@(posedge clk) disable iff (!rst_n_q) is_cond && btc_hit && bpt_taken);
	c_hit_nt: cover property (@(posedge clk) disable iff (!rst_n_q) is_cond && btc_hit && !bpt_taken);
	c_gshare: cover property (@(posedge clk) disable iff (!rst_n_q) is_cond && bpt_idx != pc_idx);
endmodule

// file: testbench/bpfe_pipe_model.sv
// Fetch and graduation pipeline stand-in feeding the prediction front end
`timescale 1ns/1ps
module bpfe_pipe_model import bpfe_pkg::*; (
	input wire logic clk, // Processor clock
	input wire logic fetch_stall, // Fetch hold from front end
	output bpfe_fetch_t fetch, // Fetch-stage instruction
	output bpfe_resolve_t resolve // Graduated branch
);
	// Quiet buses at time zero
	initial begin
		fetch = '0;
		resolve = '0;
	end

	// One fetch slot; obey waits out a stall as real fetch would
	task automatic slot(input logic [PC_W-1:0] pc, input logic br, input logic ind,
		input bit obey);
		while (obey && fetch_stall !== 1'b0) @(negedge clk);
		fetch <= '{valid: 1'b1, pc: pc, is_branch: br, is_indirect: ind};
	endtask

	// Idle payload is inverted so stale values never look valid
	task automatic fidle();
		fetch <= {1'b0, ~fetch[$bits(fetch)-2:0]};
	endtask

	// One resolved branch, with the index its prediction carried
	task automatic done(input logic [PC_W-1:0] pc, input logic tk, input logic [PC_W-1:0] tg,
		input logic [BPT_IDX_W-1:0] ix);
		resolve <= '{valid: 1'b1, pc: pc, taken: tk, target: tg, idx: ix};
	endtask

	task automatic ridle();
		resolve <= {1'b0, ~resolve[$bits(resolve)-2:0]};
	endtask
endmodule

// file: testbench/branch_prediction_front_end_tb.sv
// Self-checking bench for the branch prediction front end
`timescale 1ns/1ps
module branch_prediction_front_end_tb import bpfe_pkg::*; ;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [CTL_W-1:0] diag_ctl = '0;
	bpfe_fetch_t fetch;
	bpfe_resolve_t resolve;
	bpfe_pred_t pred;
	logic fetch_stall;
	logic fetch_bubble;
	int num_errors = 0;
	int checks = 0;

	// 40 MHz processor clock
	initial forever #12.5 clk = ~clk;

	bpfe_front_end i_bpfe_front_end (.clk(clk), .reset_n(reset_n), .diag_ctl(diag_ctl),
		.fetch(fetch), .resolve(resolve), .pred(pred), .fetch_stall(fetch_stall),
		.fetch_bubble(fetch_bubble));
	bpfe_pipe_model i_bpfe_pipe_model (.clk(clk), .fetch_stall(fetch_stall), .fetch(fetch),
		.resolve(resolve));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic results();
		$display("Errors %0d, checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// Five cycles low, then three idle cycles before the first request
	task automatic do_reset();
		reset_n = 1'b0;
		@(negedge clk);
		i_bpfe_pipe_model.fidle();
		i_bpfe_pipe_model.ridle();
		repeat (4) @(negedge clk);
		chk("pred.valid", 1'b0, pred.valid);
		chk("fetch_stall", 1'b0, fetch_stall);
		reset_n = 1'b1;
		repeat (3) @(negedge clk);
	endtask

	// Leading gap keeps fetch from being driven twice in one step
	task automatic pr(input logic [PC_W-1:0] pc, input logic tk, input logic hit,
		input logic [BPT_IDX_W-1:0] ix);
		@(negedge clk);
		i_bpfe_pipe_model.slot(pc, 1'b1, 1'b0, 1'b1);
		@(negedge clk);
		i_bpfe_pipe_model.fidle();
		chk("pred.valid", 1'b1, pred.valid);
		chk("pred.taken", tk, pred.taken);
		chk("pred.btc_hit", hit, pred.btc_hit);
		chk("pred.idx", ix, pred.idx);
		chk("fetch_bubble", hit != tk, fetch_bubble);
	endtask

	task automatic res(input logic [PC_W-1:0] pc, input logic tk, input logic [PC_W-1:0] tg,
		input logic [BPT_IDX_W-1:0] ix);
		i_bpfe_pipe_model.done(pc, tk, tg, ix);
		@(negedge clk);
		i_bpfe_pipe_model.ridle();
		@(negedge clk);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Indirect jump holds fetch; a second jump and a branch meanwhile are ignored
	task automatic t_stall();
		i_bpfe_pipe_model.slot(32'h0000_0100, 1'b0, 1'b1, 1'b1);
		for (int i = 1; i <= 7; i++) begin
			@(negedge clk);
			chk("fetch_stall", i <= JR_STALL_CYC, fetch_stall);
			chk("pred.valid", 1'b0, pred.valid);
			if (i == 1) i_bpfe_pipe_model.slot(32'h0000_0104, 1'b0, 1'b1, 1'b0);
			if (i == 3) i_bpfe_pipe_model.slot(32'h0000_0108, 1'b1, 1'b0, 1'b0);
			if (i == 4) i_bpfe_pipe_model.fidle();
		end
	endtask

	// Counter walk to both saturation ends at the top table entry
	task automatic t_sat();
		logic [8:0] outs;
		logic [8:0] exps;
		outs = 9'h187;
		exps = 9'h10F;
		diag_ctl = 32'h0800_0000;
		pr(32'hFFFF_1FFC, 1'b0, 1'b0, 11'h7FF);
		for (int i = 0; i < 9; i++) begin
			res(32'hFFFF_1FFC, outs[i], 32'h0, 11'h7FF);
			pr(32'hFFFF_1FFC, exps[i], 1'b0, 11'h7FF);
		end
	endtask

	// Two ways of one set, hit with not-taken, cache switched off
	task automatic t_btc();
		diag_ctl = '0;
		res(32'h0000_2040, 1'b1, 32'h0000_8000, 11'h010);
		res(32'h0001_2040, 1'b1, 32'h0000_9000, 11'h010);
		pr(32'h0000_2040, 1'b1, 1'b1, 11'h010);
		chk("pred.target", 32'h0000_8000, pred.target);
		pr(32'h0001_2040, 1'b1, 1'b1, 11'h010);
		chk("pred.target", 32'h0000_9000, pred.target);
		res(32'h0000_2040, 1'b0, 32'h0, 11'h010);
		res(32'h0000_2040, 1'b0, 32'h0, 11'h010);
		pr(32'h0000_2040, 1'b0, 1'b1, 11'h010);
		diag_ctl = 32'h0800_0000;
		res(32'h0000_3044, 1'b1, 32'h0000_A000, 11'h411);
		pr(32'h0000_2040, 1'b0, 1'b0, 11'h010);
		diag_ctl = '0;
		pr(32'h0000_3044, 1'b1, 1'b0, 11'h411);
	endtask

	// Eight taken predictions fill history, then every history field code
	task automatic t_hist();
		logic [7:0] m;
		for (int f = 0; f < 16; f++) begin
			do_reset();
			diag_ctl = 32'h0C00_0000;
			for (int i = 0; i < 8; i++) res(32'h0, 1'b1, 32'h0, 11'((1 << i) - 1));
			for (int i = 0; i < 8; i++) begin
				i_bpfe_pipe_model.slot(32'h0, 1'b1, 1'b0, 1'b1);
				@(negedge clk);
				chk("pred.idx", 11'((1 << i) - 1), pred.idx);
			end
			diag_ctl = 32'h0800_0000 | (32'(f) << CTL_HIST_LO);
			i_bpfe_pipe_model.slot(32'hFFFF_1000, 1'b1, 1'b0, 1'b1);
			m = f[3] ? 8'hFF : 8'((1 << f[2:0]) - 1);
			@(negedge clk);
			i_bpfe_pipe_model.fidle();
			chk("pred.idx", {3'h4, m}, pred.idx);
		end
	endtask

	// Main sequence
	initial begin
		do_reset();
		t_stall();
		t_sat();
		t_btc();
		t_hist();
		results();
	end

	// Watchdog: the whole run needs well under 10000 cycles
	initial begin
		#(25 * 10000);
		num_errors++;
		results();
	end
endmodule
